// [src/acc_pkg.sv]
// Package: register map, field positions and shared types for the calibration control block
package acc_pkg;
   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam logic [7:0] CAL_CTRL_ADDR  = 8'hF5;
   localparam logic [7:0] CAL_CTRL_RESET = 8'h00;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int BIT_BUSY     = 7;
   localparam int BIT_GAIN_DIS = 6;
   localparam int BIT_AVG_HI   = 5;
   localparam int BIT_AVG_LO   = 4;
   localparam int BIT_RSVD3    = 3;
   localparam int BIT_RSVD2    = 2;
   localparam int BIT_CAL_TYPE = 1;
   localparam int BIT_CAL_STRT = 0;

   // ----------------------------------------------------------------
   // Averaging counts per select code
   // ----------------------------------------------------------------
   localparam logic [5:0] AVG_CNT_00 = 6'h0F;
   localparam logic [5:0] AVG_CNT_01 = 6'h01;
   localparam logic [5:0] AVG_CNT_10 = 6'h1F;
   localparam logic [5:0] AVG_CNT_11 = 6'h3F;

   // ----------------------------------------------------------------
   // Converter data width and sequencer timing
   // ----------------------------------------------------------------
   localparam int DATA_W      = 12;
   localparam int ACQ_CYCLES  = 4;
   localparam int SYNC_CYCLES = 1;

   typedef enum logic [2:0] {
      ACC_IDLE,
      ACC_SYNC,
      ACC_ACQ,
      ACC_CONV,
      ACC_DONE
   } acc_phase_e;

   // Core-side register access
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } acc_sfr_req_s;
endpackage : acc_pkg

// [src/acc_sar_seq.sv]
// Successive-approximation sequencer: acquisition, bit trials and result latch
module acc_sar_seq #(
   parameter int W       = acc_pkg::DATA_W,
   parameter int ACQ_CYC = acc_pkg::ACQ_CYCLES
) (
   input  wire logic         i_clk,
   input  wire logic         i_resetn,
   input  wire logic         i_start,
   input  wire logic         i_cmp,
   output logic              o_hold,
   output logic [W-1:0]      o_trial,
   output logic [W-1:0]      o_result,
   output logic              o_done
);
   typedef struct packed {
      acc_pkg::acc_phase_e phase;
      logic [3:0]          cnt;
      logic [W-1:0]        sar;
      logic [W-1:0]        bitm;
      logic [W-1:0]        result;
      logic                done;
      logic                hold;
   } acc_seq_s;

   acc_seq_s st_ff, nxt_st;

   // ----------------------------------------------------------------
   // Phase sequencing without software involvement
   // ----------------------------------------------------------------
   always_comb begin
      logic [W-1:0] kept;
      kept        = '0;
      nxt_st      = st_ff;
      nxt_st.done = 1'b0;
      case (st_ff.phase)
         acc_pkg::ACC_IDLE: begin
            if (i_start) begin
               nxt_st.phase = acc_pkg::ACC_SYNC;
               nxt_st.cnt   = 4'(acc_pkg::SYNC_CYCLES - 1);
            end
         end
         acc_pkg::ACC_SYNC: begin
            if (st_ff.cnt == 4'h0) begin
               nxt_st.phase = acc_pkg::ACC_ACQ;
               nxt_st.cnt   = 4'(ACQ_CYC - 1);
            end else begin
               nxt_st.cnt = st_ff.cnt - 4'h1;
            end
         end
         acc_pkg::ACC_ACQ: begin
            // Track phase; input switches closed
            if (st_ff.cnt == 4'h0) begin
               nxt_st.phase = acc_pkg::ACC_CONV;
               nxt_st.bitm  = {1'b1, {(W-1){1'b0}}};
               nxt_st.sar   = {1'b1, {(W-1){1'b0}}};
            end else begin
               nxt_st.cnt = st_ff.cnt - 4'h1;
            end
         end
         acc_pkg::ACC_CONV: begin
            // Keep trial bit when comparator says charge not exceeded
            kept = i_cmp ? st_ff.sar : (st_ff.sar & ~st_ff.bitm);
            if (st_ff.bitm[0]) begin
               nxt_st.result = kept;
               nxt_st.phase  = acc_pkg::ACC_DONE;
            end else begin
               nxt_st.bitm = st_ff.bitm >> 1;
               nxt_st.sar  = kept | (st_ff.bitm >> 1);
            end
         end
         acc_pkg::ACC_DONE: begin
            nxt_st.done  = 1'b1;
            nxt_st.phase = acc_pkg::ACC_IDLE;
         end
         default: nxt_st.phase = acc_pkg::ACC_IDLE;
      endcase
      // Hold flag registered with the phase so the pin comes from a flop
      nxt_st.hold = (nxt_st.phase == acc_pkg::ACC_CONV);
   end

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign o_hold   = st_ff.hold;
   assign o_trial  = st_ff.sar;
   assign o_result = st_ff.result;
   assign o_done   = st_ff.done;
endmodule : acc_sar_seq

// [src/acc_cal_ctrl.sv]
// Calibration control register and sequencer for the 12-bit converter
module acc_cal_ctrl #(
   parameter int W = acc_pkg::DATA_W
) (
   input  wire logic                 i_clk,
   input  wire logic                 i_resetn,
   input  wire acc_pkg::acc_sfr_req_s i_sfr,
   output logic [7:0]                o_sfr_rdata,
   input  wire logic                 i_conv_start,
   input  wire logic                 i_cmp,
   output logic                      o_hold,
   output logic [W-1:0]              o_trial,
   output logic [W-1:0]              o_result,
   output logic                      o_conv_done,
   output logic                      o_cal_active,
   output logic                      o_cal_gain,
   output logic [W+5:0]              o_cal_sum,
   output logic                      o_cal_sum_valid
);
   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      logic          gain_dis;
      logic [1:0]    avg_sel;
      logic          rsvd3;
      logic          rsvd2;
      logic          cal_type;
      logic          cal_start;
      logic          conv_busy;
      logic          cal_busy;
      logic [5:0]    left;
      logic [W+5:0]  acc;
      logic [W+5:0]  sum;
      logic          sum_valid;
      logic          conv_done;
      logic          run_gain;
      logic [7:0]    rdata;
   } acc_ctrl_s;

   acc_ctrl_s st_ff, nxt_st;
   logic      seq_start;
   logic      seq_done;
   logic      seq_hold;
   logic [W-1:0] seq_trial;
   logic [W-1:0] seq_result;

   // Averaging count per select code
   function automatic logic [5:0] avg_count(input logic [1:0] sel);
      case (sel)
         2'b00:   avg_count = acc_pkg::AVG_CNT_00;
         2'b01:   avg_count = acc_pkg::AVG_CNT_01;
         2'b10:   avg_count = acc_pkg::AVG_CNT_10;
         default: avg_count = acc_pkg::AVG_CNT_11;
      endcase
   endfunction : avg_count

   // ----------------------------------------------------------------
   // Converter sequencer
   // ----------------------------------------------------------------
   acc_sar_seq #(
      .W       (W),
      .ACQ_CYC (acc_pkg::ACQ_CYCLES)
   ) u_seq (
      .i_clk    (i_clk),
      .i_resetn (i_resetn),
      .i_start  (seq_start),
      .i_cmp    (i_cmp),
      .o_hold   (seq_hold),
      .o_trial  (seq_trial),
      .o_result (seq_result),
      .o_done   (seq_done)
   );

   // Sequencer is kicked by a new conversion or each calibration reading
   always_comb begin
      seq_start = 1'b0;
      if (nxt_st.conv_busy && !st_ff.conv_busy) begin
         seq_start = 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // Register writes, busy tracking and averaging
   // ----------------------------------------------------------------
   always_comb begin
      logic wr_hit;
      logic busy;
      wr_hit = i_sfr.wr && (i_sfr.addr == acc_pkg::CAL_CTRL_ADDR);
      busy   = st_ff.conv_busy | st_ff.cal_busy;
      nxt_st = st_ff;
      nxt_st.sum_valid = 1'b0;
      nxt_st.conv_done = 1'b0;

      // Config bits are frozen while busy so a run sees stable settings
      if (wr_hit && !busy) begin
         nxt_st.gain_dis = i_sfr.wdata[acc_pkg::BIT_GAIN_DIS];
         nxt_st.avg_sel  = {i_sfr.wdata[acc_pkg::BIT_AVG_HI], i_sfr.wdata[acc_pkg::BIT_AVG_LO]};
         nxt_st.rsvd3    = i_sfr.wdata[acc_pkg::BIT_RSVD3];
         nxt_st.rsvd2    = i_sfr.wdata[acc_pkg::BIT_RSVD2];
         nxt_st.cal_type = i_sfr.wdata[acc_pkg::BIT_CAL_TYPE];
         if (i_sfr.wdata[acc_pkg::BIT_CAL_STRT]) begin
            nxt_st.cal_start = 1'b1;
            nxt_st.cal_busy  = 1'b1;
            // Gain run skipped when disabled; start clears at once
            nxt_st.run_gain  = i_sfr.wdata[acc_pkg::BIT_CAL_TYPE];
            nxt_st.left      = avg_count({i_sfr.wdata[acc_pkg::BIT_AVG_HI],
                                          i_sfr.wdata[acc_pkg::BIT_AVG_LO]});
            nxt_st.acc       = '0;
            if (i_sfr.wdata[acc_pkg::BIT_CAL_TYPE] && i_sfr.wdata[acc_pkg::BIT_GAIN_DIS]) begin
               nxt_st.cal_start = 1'b0;
               nxt_st.cal_busy  = 1'b0;
            end
         end
      end

      // Each calibration reading or normal conversion occupies the sequencer
      if (!st_ff.conv_busy && ((st_ff.cal_busy && st_ff.left != 6'h00) || (i_conv_start && !busy))) begin
         nxt_st.conv_busy = 1'b1;
      end

      if (seq_done) begin
         nxt_st.conv_busy = 1'b0;
         if (st_ff.cal_busy) begin
            nxt_st.acc  = st_ff.acc + {6'h00, seq_result};
            nxt_st.left = st_ff.left - 6'h01;
            if (st_ff.left == 6'h01) begin
               nxt_st.sum       = st_ff.acc + {6'h00, seq_result};
               nxt_st.sum_valid = 1'b1;
               nxt_st.cal_busy  = 1'b0;
               nxt_st.cal_start = 1'b0;
            end
         end else begin
            nxt_st.conv_done = 1'b1;
         end
      end

      // Registered read data, reserved bits read back as written
      nxt_st.rdata = {nxt_st.conv_busy | nxt_st.cal_busy, nxt_st.gain_dis, nxt_st.avg_sel,
                      nxt_st.rsvd3, nxt_st.rsvd2, nxt_st.cal_type, nxt_st.cal_start};
   end

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign o_sfr_rdata     = st_ff.rdata;
   assign o_hold          = seq_hold;
   assign o_trial         = seq_trial;
   assign o_result        = seq_result;
   assign o_conv_done     = st_ff.conv_done;
   assign o_cal_active    = st_ff.cal_busy;
   assign o_cal_gain      = st_ff.run_gain;
   assign o_cal_sum       = st_ff.sum;
   assign o_cal_sum_valid = st_ff.sum_valid;
endmodule : acc_cal_ctrl

// [bench/acc_cal_ctrl_checker.sv]
// Port-level assertions for the calibration control block
module acc_cal_ctrl_checker #(
   parameter int W = 12
) (
   input wire logic                  i_clk,
   input wire logic                  i_resetn,
   input wire acc_pkg::acc_sfr_req_s i_sfr,
   input wire logic [7:0]            o_sfr_rdata,
   input wire logic                  i_conv_start,
   input wire logic                  i_cmp,
   input wire logic                  o_hold,
   input wire logic [W-1:0]          o_trial,
   input wire logic [W-1:0]          o_result,
   input wire logic                  o_conv_done,
   input wire logic                  o_cal_active,
   input wire logic                  o_cal_gain,
   input wire logic [W+5:0]          o_cal_sum,
   input wire logic                  o_cal_sum_valid
);
   timeunit 1ns;
   timeprecision 1ps;
   // ------------------------------------------------------------
   // Rules
   // ------------------------------------------------------------
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_resetn);
   wire busy = o_sfr_rdata[7];
   wire cfg_wr = i_sfr.wr && i_sfr.addr == 8'hF5;
   // Busy must follow a taken conversion request by one edge
   a_conv_sets_busy: assert property (i_conv_start && !busy |=> busy)
      else $error("busy missing after conversion request");
   a_conv_ends: assert property (i_conv_start && !busy |-> ##[1:30] o_conv_done)
      else $error("conversion never finished");
   a_done_clears: assert property (o_conv_done |-> ##[0:1] !busy)
      else $error("busy stuck after conversion");
   a_cal_end_clears: assert property (o_cal_sum_valid |-> !busy && !o_sfr_rdata[0])
      else $error("busy or start left set after calibration");
   a_hold_in_busy: assert property (o_hold |-> busy)
      else $error("trial phase outside busy");
   a_gain_skipped: assert property (o_cal_active && o_cal_gain |-> !o_sfr_rdata[6])
      else $error("gain run while disabled");
   a_type_follows: assert property (o_cal_active |-> o_cal_gain == o_sfr_rdata[1] && busy)
      else $error("calibration type mismatch");
   // Start bit may still fall at the end of a run that a late write overlaps
   a_busy_wr_ignored: assert property (busy && cfg_wr |=> $stable(o_sfr_rdata[6:1]) && (o_cal_sum_valid || $stable(o_sfr_rdata[0])))
      else $error("write taken while busy");
   a_done_pulse: assert property (o_conv_done |=> !o_conv_done)
      else $error("done longer than one cycle");
   // Main scenarios reached
   c_conv: cover property (o_conv_done);
   c_sum: cover property (o_cal_sum_valid);
   c_gain: cover property (o_cal_active && o_cal_gain);
endmodule : acc_cal_ctrl_checker

bind acc_cal_ctrl acc_cal_ctrl_checker #(.W(W)) acc_cal_ctrl_checker_inst (.*);

// [bench/acc_cal_ctrl_test.sv]
// Self-checking testbench for the calibration control block
module acc_cal_ctrl_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic                  i_clk, i_resetn, i_conv_start, i_cmp;
   acc_pkg::acc_sfr_req_s i_sfr;
   logic [7:0]            o_sfr_rdata;
   logic                  o_hold, o_conv_done, o_cal_active, o_cal_gain, o_cal_sum_valid;
   logic [11:0]           o_trial, o_result;
   logic [17:0]           o_cal_sum;
   int                    err_total, n_tests, cycles;

   acc_cal_ctrl acc_cal_ctrl_inst (.i_clk(i_clk), .i_resetn(i_resetn), .i_sfr(i_sfr),
      .o_sfr_rdata(o_sfr_rdata), .i_conv_start(i_conv_start), .i_cmp(i_cmp), .o_hold(o_hold),
      .o_trial(o_trial), .o_result(o_result), .o_conv_done(o_conv_done),
      .o_cal_active(o_cal_active), .o_cal_gain(o_cal_gain), .o_cal_sum(o_cal_sum),
      .o_cal_sum_valid(o_cal_sum_valid));

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   task check(input logic [17:0] seen, input logic [17:0] exp);
      n_tests++;
      if (seen !== exp) begin
         err_total++;
         $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check

   task stop_test();
      if (err_total == 0 && n_tests > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : stop_test

   // Write pulse lasts one cycle; image is updated by the next falling edge
   task sfr_write(input logic [7:0] d);
      @(negedge i_clk);
      i_sfr.wr = 1'b1;
      i_sfr.addr = acc_pkg::CAL_CTRL_ADDR;
      i_sfr.wdata = d;
      @(negedge i_clk);
      i_sfr.wr = 1'b0;
   endtask : sfr_write

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   // Comparator low then high gives all-zero then all-one results
   task test_conv(input logic c);
      i_cmp = c;
      @(negedge i_clk);
      i_conv_start = 1'b1;
      @(negedge i_clk);
      i_conv_start = 1'b0;
      check(o_sfr_rdata[7], 1'b1);
      // First bit trial puts the top bit alone on the trial word
      wait (o_hold === 1'b1);
      #1;
      check(o_trial, 12'h800);
      wait (o_conv_done === 1'b1);
      #1;
      check(o_result, {12{c}});
      repeat (2) @(negedge i_clk);
      check(o_sfr_rdata[7], 1'b0);
   endtask : test_conv

   // Comparator held high, so every reading is full scale
   task test_cal(input logic [1:0] code, input int n);
      logic [7:0] w;
      w = {2'b00, code, 2'b01, code[0], 1'b1};
      sfr_write(w);
      check(o_sfr_rdata, w | 8'h80);
      check(o_cal_gain, code[0]);
      // A second start with other settings while busy must change nothing
      sfr_write({2'b01, ~code, 2'b01, ~code[0], 1'b1});
      check(o_sfr_rdata, w | 8'h80);
      wait (o_cal_sum_valid === 1'b1);
      #1;
      check(o_cal_sum, 18'(n * 4095));
      check({o_sfr_rdata[7], o_sfr_rdata[0]}, 2'b00);
   endtask : test_cal

   // Gain start with gain disabled is dropped at once
   task test_gain_off();
      sfr_write(8'h47);
      check(o_cal_active, 1'b0);
      check(o_sfr_rdata, 8'h46);
   endtask : test_gain_off

   // ------------------------------------------------------------
   // Clock, watchdog and main sequence
   // ------------------------------------------------------------
   initial begin
      i_clk = 1'b0;
      forever #5 i_clk = ~i_clk;
   end

   // Whole run needs about 2500 cycles; a generous ceiling catches hangs
   always @(posedge i_clk) begin
      cycles++;
      if (cycles == 20000) begin
         err_total++;
         stop_test();
      end
   end

   initial begin
      i_resetn = 1'b0;
      i_sfr = '0;
      i_conv_start = 1'b0;
      i_cmp = 1'b0;
      repeat (8) @(negedge i_clk);
      i_resetn = 1'b1;
      @(negedge i_clk);
      check(o_sfr_rdata, 8'h00);
      test_conv(1'b0);
      test_conv(1'b1);
      test_cal(2'b00, 15);
      test_cal(2'b01, 1);
      test_cal(2'b10, 31);
      test_cal(2'b11, 63);
      test_gain_off();
      stop_test();
   end
endmodule : acc_cal_ctrl_test
